// >>> verilog/mhcr_top.sv
/*
 Miscellaneous host configuration register with its effects: wake
 support mirror, stopped-link access answers, pin routing to the
 two-wire bus, clock gate bypasses and clock-run keep-alive.
 Assumes a host configuration port with one-cycle read and write
 strobes, a link access port from the host bus logic, and an
 open-drain clock-run line resolved outside.
*/
`timescale 1ns/1ns
`default_nettype none
module mhcr_top
   import mhcr_pkg::*;
(
   input  wire logic        CLK,              // Host clock, 125 MHz
   input  wire logic        RESET,            // Synchronous reset, active high
   // Configuration access
   input  wire logic        CFG_WR,           // Write strobe, one cycle
   input  wire logic        CFG_RD,           // Read strobe, one cycle
   input  wire logic [7:0]  CFG_ADDR,         // Byte offset, dword aligned
   input  wire logic [3:0]  CFG_BE,           // Byte enables for writes
   input  wire logic [31:0] CFG_WDATA,        // Write data
   output logic             CFG_ACK,          // Answer pulse for either strobe
   output logic             CFG_HIT,          // Answer addressed a mapped word
   output logic [31:0]      CFG_RDATA,        // Read data, valid with CFG_ACK
   output logic             WAKE_DEEP_OFF,    // Wake from deep off support bit
   // Host access to link-domain registers
   input  wire logic        LINK_REQ,         // Access request pulse
   input  wire logic        LINK_CLK_RUNNING, // Link clock currently active
   input  wire logic        LINK_DONE,        // Link finished forwarded access
   input  wire logic [31:0] LINK_DATA,        // Link read data with LINK_DONE
   output logic             LINK_FWD,         // Forward request to link, pulse
   output logic             LINK_ACK,         // Access completed, pulse
   output logic             LINK_ABORT,       // Target abort for access, pulse
   output logic [31:0]      LINK_RDATA,       // Read data with LINK_ACK
   // General pins and two-wire serial bus
   input  wire logic        GP2_IN,           // Pin two level
   input  wire logic        GP3_IN,           // Pin three level
   output logic             GP2_OUT,          // Pin two drive value
   output logic             GP2_OE,           // Pin two drive enable
   output logic             GP3_OUT,          // Pin three drive value
   output logic             GP3_OE,           // Pin three drive enable
   input  wire logic [1:0]  GP_DATA,          // Pin values from general logic
   input  wire logic [1:0]  GP_DIR,           // Pin enables from general logic
   output logic             SER_SCL_IN,       // Serial clock seen by serial bus
   output logic             SER_SDA_IN,       // Serial data seen by serial bus
   // Clock control
   input  wire logic        LINK_CLK_WANT,    // Link logic asks for its clock
   input  wire logic        HOST_CLK_WANT,    // Host logic asks for its clock
   output logic             LINK_CLK_EN,      // Link clock gate enable
   output logic             HOST_CLK_EN,      // Host clock gate enable
   input  wire logic        CLKRUN_N_IN,      // Clock-run line level
   output logic             CLKRUN_N_OUT,     // Clock-run drive value
   output logic             CLKRUN_N_OE       // Clock-run drive enable
);

   logic [31:0]        misc_r;
   logic [31:0]        misc_nxt;
   logic [31:0]        misc_rd;
   logic [31:0]        wr_mask;
   logic               misc_sel;
   logic               pmcap_sel;
   logic               no_abort_s;
   logic               keep_s;
   mhcr_link_state_t   la_state_r;
   mhcr_clkrun_state_t cr_state_r;
   logic [2:0]         cr_cnt_r;
   logic               clkrun_need;

   mhcr_sync_if #(.WIDTH(MHCR_SYNC_WIDTH)) sync_bus ();

   // Configuration register
   // Writes land at the strobe edge; the answer follows one cycle later

   assign misc_sel  = (CFG_ADDR == MHCR_MISC_OFFSET);
   assign pmcap_sel = (CFG_ADDR == MHCR_PMCAP_OFFSET);

   assign wr_mask = MHCR_MISC_WR_MASK
                  & {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};

   // Reserved positions never store, so they always read back zero
   assign misc_nxt = (misc_r & ~wr_mask) | (CFG_WDATA & wr_mask);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         misc_r <= MHCR_MISC_RESET;
      end else if (CFG_WR && misc_sel) begin
         misc_r <= misc_nxt;
      end
   end

   assign misc_rd = misc_r & MHCR_MISC_WR_MASK;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         CFG_ACK   <= 1'b0;
         CFG_HIT   <= 1'b0;
         CFG_RDATA <= 32'h0000_0000;
      end else begin
         CFG_ACK <= CFG_WR | CFG_RD;
         CFG_HIT <= (CFG_WR | CFG_RD) & (misc_sel | pmcap_sel);
         if (CFG_RD && misc_sel) begin
            CFG_RDATA <= misc_rd;
         end else if (CFG_RD && pmcap_sel) begin
            // Only the mirrored wake bit of this word is held here
            CFG_RDATA <= 32'h0000_0000;
            CFG_RDATA[MHCR_PMCAP_WAKE_POS] <= misc_r[MHCR_WAKE_POS];
         end else if (CFG_RD) begin
            CFG_RDATA <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         WAKE_DEEP_OFF <= 1'b0;
      end else begin
         WAKE_DEEP_OFF <= misc_r[MHCR_WAKE_POS];
      end
   end

   // Synchronised control bits
   // Two cycles of lag are harmless: software changes these bits rarely

   assign sync_bus.d[MHCR_SYNC_NO_ABORT] = misc_r[MHCR_NO_ABORT_POS];
   assign sync_bus.d[MHCR_SYNC_KEEP]     = misc_r[MHCR_KEEP_POS];

   mhcr_sync #(
      .WIDTH (MHCR_SYNC_WIDTH)
   ) u_sync (
      .clk   (CLK),
      .reset (RESET),
      .port  (sync_bus)
   );

   // Users see only the synchronised copies, never the raw register bits
   assign no_abort_s = sync_bus.q[MHCR_SYNC_NO_ABORT];
   assign keep_s     = sync_bus.q[MHCR_SYNC_KEEP];

   // Link-domain register access
   // Only one forwarded access is outstanding; the link answers in its own time

   always_ff @(posedge CLK) begin
      if (RESET) begin
         la_state_r <= MHCR_LA_IDLE;
      end else begin
         unique case (la_state_r)
            MHCR_LA_IDLE: begin
               if (LINK_REQ && LINK_CLK_RUNNING) begin
                  la_state_r <= MHCR_LA_WAIT;
               end
            end
            MHCR_LA_WAIT: begin
               if (LINK_DONE) begin
                  la_state_r <= MHCR_LA_IDLE;
               end
            end
            default: begin
               la_state_r <= MHCR_LA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         LINK_FWD <= 1'b0;
      end else begin
         LINK_FWD <= (la_state_r == MHCR_LA_IDLE) && LINK_REQ && LINK_CLK_RUNNING;
      end
   end

   // A request arriving while a forwarded one is pending is ignored
   // Limitation: the host must wait for the answer before the next request
   always_ff @(posedge CLK) begin
      if (RESET) begin
         LINK_ACK   <= 1'b0;
         LINK_ABORT <= 1'b0;
         LINK_RDATA <= 32'h0000_0000;
      end else begin
         LINK_ACK   <= 1'b0;
         LINK_ABORT <= 1'b0;
         if (la_state_r == MHCR_LA_WAIT && LINK_DONE) begin
            LINK_ACK   <= 1'b1;
            LINK_RDATA <= LINK_DATA;
         end else if (la_state_r == MHCR_LA_IDLE && LINK_REQ && !LINK_CLK_RUNNING) begin
            if (no_abort_s) begin
               LINK_ACK   <= 1'b1;
               LINK_RDATA <= MHCR_INACTIVE_DATA;
            end else begin
               LINK_ABORT <= 1'b1;
            end
         end
      end
   end

   // General pins and serial bus routing
   // Pins are released when routed, so no drive fights the serial bus

   always_ff @(posedge CLK) begin
      if (RESET) begin
         GP2_OUT <= 1'b0;
         GP2_OE  <= 1'b0;
         GP3_OUT <= 1'b0;
         GP3_OE  <= 1'b0;
      end else if (misc_r[MHCR_ROUTE_POS]) begin
         GP2_OUT <= 1'b0;
         GP2_OE  <= 1'b0;
         GP3_OUT <= 1'b0;
         GP3_OE  <= 1'b0;
      end else begin
         GP2_OUT <= GP_DATA[0];
         GP2_OE  <= GP_DIR[0];
         GP3_OUT <= GP_DATA[1];
         GP3_OE  <= GP_DIR[1];
      end
   end

   // Idle serial bus lines rest high when the pins are not routed
   // Pin levels pass one flop, trading a cycle of lag for clean outputs
   always_ff @(posedge CLK) begin
      if (RESET) begin
         SER_SCL_IN <= 1'b1;
         SER_SDA_IN <= 1'b1;
      end else if (misc_r[MHCR_ROUTE_POS]) begin
         SER_SCL_IN <= GP3_IN;
         SER_SDA_IN <= GP2_IN;
      end else begin
         SER_SCL_IN <= 1'b1;
         SER_SDA_IN <= 1'b1;
      end
   end

   // Clock gating; bypass bits are for test only and software keeps them clear
   // Enables are registered, so a gate opens one cycle after its request;
   // a request must therefore come a cycle before the clock is needed

   always_ff @(posedge CLK) begin
      if (RESET) begin
         LINK_CLK_EN <= 1'b0;
         HOST_CLK_EN <= 1'b1;
      end else begin
         LINK_CLK_EN <= misc_r[MHCR_LGATE_POS] | LINK_CLK_WANT;
         HOST_CLK_EN <= misc_r[MHCR_HGATE_POS] | HOST_CLK_WANT;
      end
   end

   // Clock-run keep-alive
   // The line is driven only briefly and then released, so the pull-up
   // settles before it is looked at again

   // A pending link access also needs the host clock, whatever bit 0 says
   assign clkrun_need = keep_s | (la_state_r == MHCR_LA_WAIT) | LINK_REQ;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         cr_state_r <= MHCR_CR_IDLE;
         cr_cnt_r   <= 3'h0;
      end else begin
         unique case (cr_state_r)
            MHCR_CR_IDLE: begin
               // A released line is a request to stop; refuse it only when needed
               if (CLKRUN_N_IN && clkrun_need) begin
                  cr_state_r <= MHCR_CR_HOLD;
                  cr_cnt_r   <= MHCR_CLKRUN_HOLD_CYC - 3'h1;
               end
            end
            MHCR_CR_HOLD: begin
               if (cr_cnt_r == 3'h0) begin
                  cr_state_r <= MHCR_CR_GAP;
                  cr_cnt_r   <= MHCR_CLKRUN_GAP_CYC - 3'h1;
               end else begin
                  cr_cnt_r <= cr_cnt_r - 3'h1;
               end
            end
            MHCR_CR_GAP: begin
               if (cr_cnt_r == 3'h0) begin
                  cr_state_r <= MHCR_CR_IDLE;
               end else begin
                  cr_cnt_r <= cr_cnt_r - 3'h1;
               end
            end
            default: begin
               cr_state_r <= MHCR_CR_IDLE;
               cr_cnt_r   <= 3'h0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         CLKRUN_N_OUT <= 1'b1;
         CLKRUN_N_OE  <= 1'b0;
      end else if (cr_state_r == MHCR_CR_IDLE && CLKRUN_N_IN && clkrun_need) begin
         CLKRUN_N_OUT <= 1'b0;
         CLKRUN_N_OE  <= 1'b1;
      end else if (cr_state_r == MHCR_CR_HOLD && cr_cnt_r != 3'h0) begin
         CLKRUN_N_OUT <= 1'b0;
         CLKRUN_N_OE  <= 1'b1;
      end else begin
         CLKRUN_N_OUT <= 1'b1;
         CLKRUN_N_OE  <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// >>> verilog/mhcr_pkg.sv
/*
 Constants for the miscellaneous host configuration register block:
 register offsets, field positions, reset values and protocol counts.
 Assumes a 32-bit host configuration space addressed by byte offset.
*/
// Overview of operation
// - Reserved bits 31:16 and 14:5 read zero
// - Bit 15 mirrored into wake support at 46h
// - Bit 4 resets zero; stopped-link access aborts
// - Bit 4 set: complete access, return FFh
// - Bit 3 routes pins three/two to serial bus
// - Routed pins are released to high impedance
// - Bit 2 forces link clock gate open
// - Bit 1 forces host clock gate open
// - Bit 0 set: clock-run keeps host clock running
// - Bit 0 clear: host clock may be stopped
package mhcr_pkg;

   localparam logic [7:0]  MHCR_MISC_OFFSET   = 8'hf0;
   // Dword holding the power management capabilities word at 46h
   localparam logic [7:0]  MHCR_PMCAP_OFFSET  = 8'h44;
   localparam int          MHCR_PMCAP_WAKE_POS = 31;

   localparam logic [31:0] MHCR_MISC_RESET    = 32'h0000_0000;
   localparam logic [31:0] MHCR_MISC_WR_MASK  = 32'h0000_801f;

   localparam int          MHCR_WAKE_POS      = 15;
   localparam int          MHCR_NO_ABORT_POS  = 4;
   localparam int          MHCR_ROUTE_POS     = 3;
   localparam int          MHCR_LGATE_POS     = 2;
   localparam int          MHCR_HGATE_POS     = 1;
   localparam int          MHCR_KEEP_POS      = 0;

   localparam logic [31:0] MHCR_INACTIVE_DATA = 32'h0000_00ff;

   // Synchroniser bit lanes
   localparam int          MHCR_SYNC_WIDTH    = 2;
   localparam int          MHCR_SYNC_NO_ABORT = 0;
   localparam int          MHCR_SYNC_KEEP     = 1;

   // Cycles the clock-run line is driven low to refuse a stop
   localparam logic [2:0]  MHCR_CLKRUN_HOLD_CYC = 3'h2;
   // Quiet cycles after release so the pulled-up line is not re-read as a stop
   localparam logic [2:0]  MHCR_CLKRUN_GAP_CYC  = 3'h2;

   typedef enum logic [1:0] {
      MHCR_LA_IDLE,
      MHCR_LA_WAIT
   } mhcr_link_state_t;

   typedef enum logic [1:0] {
      MHCR_CR_IDLE,
      MHCR_CR_HOLD,
      MHCR_CR_GAP
   } mhcr_clkrun_state_t;

endpackage

// >>> verilog/mhcr_sync_if.sv
/*
 Carrier between the register block and its synchroniser: control
 bits going in, synchronised copies coming out.
 Assumes both ends share the block clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface mhcr_sync_if #(parameter int WIDTH = 2);
   logic [WIDTH-1:0] d;
   logic [WIDTH-1:0] q;
   modport src (output d, input q);
   modport snk (input d, output q);
endinterface
`default_nettype wire

// >>> verilog/mhcr_sync.sv
/*
 Two-flop level synchroniser, one lane per bit of the carrier.
 Assumes levels that hold for at least two clock cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module mhcr_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic  clk,     // Block clock
   input  wire logic  reset,   // Synchronous reset, active high
   mhcr_sync_if.snk   port     // Levels in, synchronised levels out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // First stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= port.d;
         sync_r <= meta_r;
      end
   end

   assign port.q = sync_r;
endmodule
`default_nettype wire

// >>> bench/mhcr_top_assertions.sv
/* Port assertions for the misc host config block.
   Assumes it is bound to mhcr_top; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module mhcr_top_assertions
   import mhcr_pkg::*;
(
   input wire logic        CLK,              // Clock
   input wire logic        RESET,            // Reset
   input wire logic        CFG_WR,           // Write
   input wire logic        CFG_RD,           // Read
   input wire logic [7:0]  CFG_ADDR,         // Offset
   input wire logic [3:0]  CFG_BE,           // Lanes
   input wire logic [31:0] CFG_WDATA,        // Data
   input wire logic        CFG_ACK,          // Answer
   input wire logic        CFG_HIT,          // Mapped
   input wire logic [31:0] CFG_RDATA,        // Read data
   input wire logic        WAKE_DEEP_OFF,    // Wake bit
   input wire logic        LINK_REQ,         // Request
   input wire logic        LINK_CLK_RUNNING, // Running
   input wire logic        LINK_DONE,        // Done
   input wire logic        LINK_FWD,         // Forward
   input wire logic        LINK_ACK,         // Ack
   input wire logic        LINK_ABORT,       // Abort
   input wire logic [31:0] LINK_RDATA,       // Data
   input wire logic        GP3_IN,           // Pin level
   input wire logic        GP3_OUT,          // Pin value
   input wire logic        GP3_OE,           // Pin enable
   input wire logic [1:0]  GP_DIR,           // Enables
   input wire logic        SER_SCL_IN,       // Serial clock
   input wire logic        LINK_CLK_WANT,    // Link want
   input wire logic        HOST_CLK_WANT,    // Host want
   input wire logic        LINK_CLK_EN,      // Link gate
   input wire logic        HOST_CLK_EN,      // Host gate
   input wire logic        CLKRUN_N_OUT,     // Line value
   input wire logic        CLKRUN_N_OE       // Line enable
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   AST_CFG_ACK: assert property ((CFG_WR || CFG_RD) |=> CFG_ACK)
      else $error("config answer missing");
   AST_CFG_HIT: assert property (CFG_HIT |-> CFG_ACK &&
      $past(CFG_ADDR == MHCR_MISC_OFFSET || CFG_ADDR == MHCR_PMCAP_OFFSET))
      else $error("hit on unmapped offset");
   AST_RSVD: assert property (CFG_RD && CFG_ADDR == MHCR_MISC_OFFSET |=>
      CFG_RDATA[31:16] == 16'h0 && CFG_RDATA[14:5] == 10'h0)
      else $error("reserved bits not zero");
   AST_WAKE: assert property ($rose(WAKE_DEEP_OFF) |->
      $past(CFG_WR && CFG_ADDR == MHCR_MISC_OFFSET && CFG_BE[1] && CFG_WDATA[15], 2))
      else $error("wake bit rose without write");
   AST_ABORT: assert property (LINK_ABORT |-> $past(LINK_REQ && !LINK_CLK_RUNNING))
      else $error("abort without stopped access");
   AST_FWD: assert property (LINK_FWD |-> $past(LINK_REQ && LINK_CLK_RUNNING))
      else $error("forward without running access");
   AST_FF: assert property (LINK_ACK && !$past(LINK_DONE) |->
      LINK_RDATA == MHCR_INACTIVE_DATA)
      else $error("inactive read data wrong");
   AST_SER: assert property (!SER_SCL_IN |-> !$past(GP3_IN))
      else $error("serial clock not following pin");
   AST_HIZ: assert property (GP3_OE != $past(GP_DIR[1]) |-> !GP3_OE && !GP3_OUT)
      else $error("routed pin still driven");
   AST_LGATE: assert property (LINK_CLK_EN != $past(LINK_CLK_WANT) |-> LINK_CLK_EN)
      else $error("link gate wrong");
   AST_HGATE: assert property (!HOST_CLK_EN |-> !$past(HOST_CLK_WANT))
      else $error("host gate wrong");
   AST_CLKRUN: assert property ($rose(CLKRUN_N_OE) |-> !CLKRUN_N_OUT ##1
      (CLKRUN_N_OE && !CLKRUN_N_OUT) ##1 !CLKRUN_N_OE [*2])
      else $error("clock-run drive length wrong");
endmodule

bind mhcr_top mhcr_top_assertions mhcr_top_assertions_inst (
   .CLK, .RESET, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_BE, .CFG_WDATA, .CFG_ACK,
   .CFG_HIT, .CFG_RDATA, .WAKE_DEEP_OFF, .LINK_REQ, .LINK_CLK_RUNNING, .LINK_DONE,
   .LINK_FWD, .LINK_ACK, .LINK_ABORT, .LINK_RDATA, .GP3_IN, .GP3_OUT, .GP3_OE,
   .GP_DIR, .SER_SCL_IN, .LINK_CLK_WANT, .HOST_CLK_WANT, .LINK_CLK_EN,
   .HOST_CLK_EN, .CLKRUN_N_OUT, .CLKRUN_N_OE
);
`default_nettype wire

// >>> bench/mhcr_host_model.sv
/* Far-side model: answers forwarded link accesses, pulls clock-run up.
   Assumes the block clock and reset. */
`timescale 1ns/1ns
`default_nettype none
module mhcr_host_model (
   input  wire logic        CLK,          // Clock
   input  wire logic        RESET,        // Reset
   input  wire logic        LINK_FWD,     // Forwarded access
   input  wire logic [2:0]  dly,          // Answer delay
   input  wire logic [31:0] rsp,          // Answer data
   input  wire logic        CLKRUN_N_OUT, // Line value
   input  wire logic        CLKRUN_N_OE,  // Line enable
   output logic             LINK_DONE,    // Access done
   output logic [31:0]      LINK_DATA,    // Data with done
   output logic             CLKRUN_N_IN   // Resolved line
);
   logic [2:0] cnt_r;
   logic       busy_r;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         busy_r    <= 1'b0;
         cnt_r     <= 3'h0;
         LINK_DONE <= 1'b0;
      end else begin
         LINK_DONE <= busy_r && cnt_r == 3'h0;
         if (LINK_FWD) begin
            busy_r <= 1'b1;
            cnt_r  <= dly;
         end else if (busy_r && cnt_r == 3'h0) begin
            busy_r <= 1'b0;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 3'h1;
         end
      end
   end
   // Released data is inverted so a stale value never passes
   assign LINK_DATA   = LINK_DONE ? rsp : ~rsp;
   // Pull-up on the open-drain line
   assign CLKRUN_N_IN = CLKRUN_N_OE ? CLKRUN_N_OUT : 1'b1;
endmodule
`default_nettype wire

// >>> bench/mhcr_tb.sv
/* Self-checking bench for mhcr_top against a register model.
   Assumes the design package and the host partner model. */
`timescale 1ns/1ns
`default_nettype none
module tb
   import mhcr_pkg::*;
;
   logic        CLK, RESET, CFG_WR, CFG_RD, CFG_ACK, CFG_HIT, WAKE_DEEP_OFF;
   logic        LINK_REQ, LINK_CLK_RUNNING, LINK_DONE, LINK_FWD, LINK_ACK, LINK_ABORT;
   logic        GP2_IN, GP3_IN, GP2_OUT, GP2_OE, GP3_OUT, GP3_OE, SER_SCL_IN, SER_SDA_IN;
   logic        LINK_CLK_WANT, HOST_CLK_WANT, LINK_CLK_EN, HOST_CLK_EN;
   logic        CLKRUN_N_IN, CLKRUN_N_OUT, CLKRUN_N_OE;
   logic [7:0]  CFG_ADDR;
   logic [3:0]  CFG_BE, be;
   logic [31:0] CFG_WDATA, CFG_RDATA, LINK_DATA, LINK_RDATA, rsp, wd, bm;
   logic [31:0] m = 32'h0;
   logic [31:0] seed = 32'h150d;
   logic [1:0]  GP_DATA, GP_DIR, ext;
   logic [2:0]  dly;
   logic [31:0] lq[$];
   int          miscompares = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          k;

   assign GP2_IN = GP2_OE ? GP2_OUT : ext[0];
   assign GP3_IN = GP3_OE ? GP3_OUT : ext[1];

   mhcr_top mhcr_top_inst (.CLK, .RESET, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_BE,
      .CFG_WDATA, .CFG_ACK, .CFG_HIT, .CFG_RDATA, .WAKE_DEEP_OFF, .LINK_REQ,
      .LINK_CLK_RUNNING, .LINK_DONE, .LINK_DATA, .LINK_FWD, .LINK_ACK, .LINK_ABORT,
      .LINK_RDATA, .GP2_IN, .GP3_IN, .GP2_OUT, .GP2_OE, .GP3_OUT, .GP3_OE, .GP_DATA,
      .GP_DIR, .SER_SCL_IN, .SER_SDA_IN, .LINK_CLK_WANT, .HOST_CLK_WANT,
      .LINK_CLK_EN, .HOST_CLK_EN, .CLKRUN_N_IN, .CLKRUN_N_OUT, .CLKRUN_N_OE);
   mhcr_host_model mhcr_host_model_inst (.CLK, .RESET, .LINK_FWD, .dly, .rsp,
      .CLKRUN_N_OUT, .CLKRUN_N_OE, .LINK_DONE, .LINK_DATA, .CLKRUN_N_IN);

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task close_out();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
            input logic [31:0] d, input logic [31:0] e, input logic h);
      @(negedge CLK);
      {CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = {w, !w, a, b, d};
      // The answer stands for the one cycle after the strobe edge
      @(posedge CLK) #1;
      chk({CFG_ACK, CFG_HIT}, {1'b1, h});
      if (!w) chk(CFG_RDATA, e);
      @(negedge CLK);
      {CFG_WR, CFG_RD} = 2'b00;
   endtask

   task automatic lnk(input logic run);
      logic [31:0] e;
      logic [1:0]  res;
      e   = MHCR_INACTIVE_DATA;
      res = (!run && !m[MHCR_NO_ABORT_POS]) ? 2'b01 : 2'b10;
      @(negedge CLK);
      rsp = xs();
      dly = {1'b0, rsp[1:0]};
      if (run) lq.push_back(rsp);
      {LINK_REQ, LINK_CLK_RUNNING} = {1'b1, run};
      @(negedge CLK);
      LINK_REQ = 1'b0;
      for (int i = 0; i < 40 && LINK_ACK !== 1'b1 && LINK_ABORT !== 1'b1; i++)
         @(posedge CLK) #1;
      if (run) e = lq.pop_front();
      chk({LINK_ACK, LINK_ABORT}, res);
      if (res[1]) chk(LINK_RDATA, e);
   endtask

   task automatic crun(input logic keep);
      logic [7:0] cnt;
      cnt = 8'h0;
      // Let any drive left over from the last access run out first
      repeat (6) @(posedge CLK);
      repeat (12) begin
         @(posedge CLK) #1;
         cnt = cnt + {7'h0, CLKRUN_N_OE};
      end
      chk(cnt != 8'h0, keep);
   endtask

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      {CFG_WR, CFG_RD, LINK_REQ, LINK_CLK_RUNNING, LINK_CLK_WANT, HOST_CLK_WANT} = 6'h0;
      {CFG_ADDR, CFG_BE, CFG_WDATA, GP_DATA, GP_DIR, ext, dly, rsp} = 85'h0;
      RESET = 1'b1;
      repeat (6) @(negedge CLK);
      RESET = 1'b0;
      cfg(1'b0, MHCR_MISC_OFFSET, 4'h0, 32'h0, MHCR_MISC_RESET, 1'b1);
      lnk(1'b0);
      for (k = 0; k < 32; k++) begin
         wd      = xs();
         wd[4:0] = k[4:0]; // Every low-field combination, bypasses included
         be      = wd[11:8] | 4'h1;
         bm      = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & MHCR_MISC_WR_MASK;
         m       = (m & ~bm) | (wd & bm);
         cfg(1'b1, MHCR_MISC_OFFSET, be, wd, 32'h0, 1'b1);
         cfg(1'b1, 8'h80, 4'hf, ~wd, 32'h0, 1'b0);
         cfg(1'b0, MHCR_MISC_OFFSET, 4'h0, 32'h0, m, 1'b1);
         cfg(1'b0, MHCR_PMCAP_OFFSET, 4'h0, 32'h0, {m[15], 31'h0}, 1'b1);
         cfg(1'b0, 8'h80, 4'h0, 32'h0, 32'h0, 1'b0);
         @(negedge CLK);
         rsp = xs();
         {GP_DATA, GP_DIR, ext, LINK_CLK_WANT, HOST_CLK_WANT} = rsp[7:0];
         repeat (2) @(posedge CLK);
         #1;
         chk(WAKE_DEEP_OFF, m[15]);
         chk({GP3_OE, GP2_OE}, m[3] ? 2'b00 : GP_DIR);
         chk({GP3_OUT, GP2_OUT}, m[3] ? 2'b00 : GP_DATA);
         chk({SER_SCL_IN, SER_SDA_IN}, m[3] ? ext : 2'b11);
         chk(LINK_CLK_EN, m[2] | LINK_CLK_WANT);
         chk(HOST_CLK_EN, m[1] | HOST_CLK_WANT);
         lnk(1'b0);
         lnk(1'b1);
         crun(m[0]);
      end
      close_out();
   end
endmodule
`default_nettype wire
